/* design/slm_edge.sv */
/*
 * crossing detector on the synchronised below-threshold level.
 * assumes a synchronous level input; edges are suppressed while not armed.
 */
`timescale 1ns/10ps
module slm_edge (
    input  wire logic          clk_i,
    input  wire logic          arst_n_i,
    input  wire logic          level_i,
    input  wire logic          armed_i,
    output slm_pkg::slm_edge_type edge_o
);
    logic last_reg;
    logic last_next;

    always_comb begin
        last_next = level_i;
    end

    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            last_reg <= 1'b0;
        end else begin
            last_reg <= last_next;
        end
    end

    // level high means below: rising level is the supply falling
    assign edge_o.fell = armed_i & level_i & ~last_reg;
    assign edge_o.rose = armed_i & ~level_i & last_reg;
endmodule

/* design/slm_pkg.sv */
/*
 * package of the supply level monitor register bank: offsets, field positions, reset values,
 * trigger codes and the carrier structs shared by the top and its edge leaf.
 * assumes byte-wide registers on a plain strobe port, one clock domain.
 */
package slm_pkg;

    localparam int unsigned ADDR_W = 4;
    localparam int unsigned DATA_W = 8;

    // byte addresses as printed; the port addresses bytes directly
    localparam logic [3:0] OFS_LEVEL_CTRL = 4'h8;
    localparam logic [3:0] OFS_IRQ_CTRL   = 4'h9;
    localparam logic [3:0] OFS_IRQ_FLAGS  = 4'ha;
    localparam logic [3:0] OFS_STATUS     = 4'hb;

    // field positions
    localparam int unsigned LEVEL_LSB   = 0;
    localparam int unsigned IRQ_EN_BIT  = 0;
    localparam int unsigned TRIG_LSB    = 1;
    localparam int unsigned FLAG_BIT    = 0;
    localparam int unsigned STATUS_BIT  = 0;

    localparam logic [7:0] RESET_BYTE = 8'h00;

    // threshold offset codes
    localparam logic [1:0] LEVEL_OFF                 = 2'h0;
    localparam logic [1:0] OFFSET_FIVE_PERCENT       = 2'h1;
    localparam logic [1:0] OFFSET_FIFTEEN_PERCENT    = 2'h2;
    localparam logic [1:0] OFFSET_TWENTYFIVE_PERCENT = 2'h3;

    // trigger condition codes
    localparam logic [1:0] TRIG_FALLING = 2'h0;
    localparam logic [1:0] TRIG_RISING  = 2'h1;
    localparam logic [1:0] TRIG_BOTH    = 2'h2;

    typedef struct packed {
        logic [1:0] trigger_condition_select;
        logic       monitor_irq_enable;
        logic [1:0] threshold_offset_select;
    } slm_cfg_type;

    typedef struct packed {
        logic fell;
        logic rose;
    } slm_edge_type;

endpackage

/* design/slm_sync.sv */
/*
 * two-flop synchroniser for the comparator level, the detector enable and the debug halt.
 * assumes the inputs may change at any time relative to clk_i.
 */
`timescale 1ns/10ps
module slm_sync (
    input  wire logic clk_i,
    input  wire logic arst_n_i,
    input  wire logic async_i,
    output logic      sync_o
);
    logic stage1_reg;
    logic stage2_reg;

    // stage1 feeds only stage2
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            stage1_reg <= 1'b0;
            stage2_reg <= 1'b0;
        end else begin
            stage1_reg <= async_i;
            stage2_reg <= stage1_reg;
        end
    end

    assign sync_o = stage2_reg;
endmodule

/* design/slm_top.sv */
/*
 * supply level monitor register bank: threshold offset, trigger choice, interrupt enable,
 * sticky event flag, status live while the detector runs and one level interrupt output.
 * assumes the analogue comparator drives below_i (high when supply below the monitor trip
 * point), the detector drives its enable level, and both are asynchronous to clk_i.
 */
// The address-and-strobe port was left to the implementer.
`timescale 1ns/10ps
module slm_top (
    input  wire logic                        clk_i,
    input  wire logic                        arst_n_i,
    input  wire logic [slm_pkg::ADDR_W-1:0]  addr_i,
    input  wire logic [slm_pkg::DATA_W-1:0]  wdata_i,
    input  wire logic                        wr_i,
    input  wire logic                        rd_i,
    output logic      [slm_pkg::DATA_W-1:0]  rdata_o,
    input  wire logic                        below_i,
    input  wire logic                        detector_en_i,
    input  wire logic                        debug_halt_i,
    output logic [1:0]                       threshold_offset_o,
    output logic                             monitor_on_o,
    output logic                             irq_o
);
    slm_pkg::slm_cfg_type  cfg_reg;
    slm_pkg::slm_cfg_type  cfg_next;
    logic                  flag_reg;
    logic                  flag_next;
    logic                  status_reg;
    logic                  status_next;
    logic [7:0]            rdata_reg;
    logic [7:0]            rdata_next;
    logic                  irq_reg;
    logic                  irq_next;
    logic [1:0]            thr_reg;
    logic                  on_reg;
    logic                  below_sync;
    logic                  det_en_sync;
    logic                  halt_sync;
    logic                  armed;
    logic                  hit;
    slm_pkg::slm_edge_type edge_s;

    // comparator and enable are analogue-side levels
    slm_sync u_sync_below (
        .clk_i    (clk_i),
        .arst_n_i (arst_n_i),
        .async_i  (below_i),
        .sync_o   (below_sync)
    );

    slm_sync u_sync_en (
        .clk_i    (clk_i),
        .arst_n_i (arst_n_i),
        .async_i  (detector_en_i),
        .sync_o   (det_en_sync)
    );

    slm_sync u_sync_halt (
        .clk_i    (clk_i),
        .arst_n_i (arst_n_i),
        .async_i  (debug_halt_i),
        .sync_o   (halt_sync)
    );

    // monitor off in code zero, and only meaningful with the detector running
    assign armed = det_en_sync & (cfg_reg.threshold_offset_select != slm_pkg::LEVEL_OFF);

    slm_edge u_edge (
        .clk_i    (clk_i),
        .arst_n_i (arst_n_i),
        .level_i  (below_sync),
        .armed_i  (armed),
        .edge_o   (edge_s)
    );

    function automatic logic trig_match(input logic [1:0] sel, input slm_pkg::slm_edge_type e);
        logic m;
        m = 1'b0;
        case (sel)
            slm_pkg::TRIG_FALLING: m = e.fell;
            slm_pkg::TRIG_RISING:  m = e.rose;
            slm_pkg::TRIG_BOTH:    m = e.fell | e.rose;
            default:               m = 1'b0;                         // reserved code never triggers
        endcase
        return m;
    endfunction

    assign hit = trig_match(cfg_reg.trigger_condition_select, edge_s);

    always_comb begin
        cfg_next    = cfg_reg;
        flag_next   = flag_reg;
        status_next = status_reg;
        if (wr_i) begin
            if (addr_i == slm_pkg::OFS_LEVEL_CTRL) begin
                cfg_next.threshold_offset_select = wdata_i[slm_pkg::LEVEL_LSB +: 2];
            end else if (addr_i == slm_pkg::OFS_IRQ_CTRL) begin
                cfg_next.monitor_irq_enable       = wdata_i[slm_pkg::IRQ_EN_BIT];
                cfg_next.trigger_condition_select = wdata_i[slm_pkg::TRIG_LSB +: 2];
            end else if (addr_i == slm_pkg::OFS_IRQ_FLAGS) begin
                if (wdata_i[slm_pkg::FLAG_BIT]) begin
                    flag_next = 1'b0;
                end
            end
        end
        // set beats a clear in the same cycle; no set without the detector
        if (hit) begin
            flag_next = 1'b1;
        end
        // status follows the comparator only while the detector runs, else holds; writes to it have no effect
        if (det_en_sync) begin
            status_next = below_sync;
        end
    end

    always_comb begin
        rdata_next = slm_pkg::RESET_BYTE;
        if (rd_i) begin
            if (addr_i == slm_pkg::OFS_LEVEL_CTRL) begin
                rdata_next[slm_pkg::LEVEL_LSB +: 2] = cfg_reg.threshold_offset_select;
            end else if (addr_i == slm_pkg::OFS_IRQ_CTRL) begin
                rdata_next[slm_pkg::IRQ_EN_BIT]    = cfg_reg.monitor_irq_enable;
                rdata_next[slm_pkg::TRIG_LSB +: 2] = cfg_reg.trigger_condition_select;
            end else if (addr_i == slm_pkg::OFS_IRQ_FLAGS) begin
                rdata_next[slm_pkg::FLAG_BIT] = flag_reg;
            end else if (addr_i == slm_pkg::OFS_STATUS) begin
                rdata_next[slm_pkg::STATUS_BIT] = status_reg;
            end
        end
    end

    always_comb begin
        // held off during debug halt, then returns while flag still set
        irq_next = cfg_reg.monitor_irq_enable & flag_reg & ~halt_sync;
    end

    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            cfg_reg    <= '0;
            flag_reg   <= 1'b0;
            status_reg <= 1'b0;
            rdata_reg  <= slm_pkg::RESET_BYTE;
            irq_reg    <= 1'b0;
            thr_reg    <= slm_pkg::LEVEL_OFF;
            on_reg     <= 1'b0;
        end else begin
            cfg_reg    <= cfg_next;
            flag_reg   <= flag_next;
            status_reg <= status_next;
            rdata_reg  <= rdata_next;
            irq_reg    <= irq_next;
            thr_reg    <= cfg_next.threshold_offset_select;
            on_reg     <= cfg_next.threshold_offset_select != slm_pkg::LEVEL_OFF;
        end
    end

    assign rdata_o            = rdata_reg;
    assign irq_o              = irq_reg;
    assign threshold_offset_o = thr_reg;
    assign monitor_on_o       = on_reg;
endmodule

/* sim/slm_props.sv */
/* port checker for slm_top: register bus, event flag and interrupt output relations.
   assumes one clock domain; bound to slm_top after the module. */
`timescale 1ns/10ps
module slm_props (
    input wire logic       clk_i,
    input wire logic       arst_n_i,
    input wire logic [3:0] addr_i,
    input wire logic [7:0] wdata_i,
    input wire logic       wr_i,
    input wire logic       rd_i,
    input wire logic [7:0] rdata_o,
    input wire logic       below_i,
    input wire logic       detector_en_i,
    input wire logic       debug_halt_i,
    input wire logic [1:0] threshold_offset_o,
    input wire logic       monitor_on_o,
    input wire logic       irq_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (!arst_n_i);
    property p_on; monitor_on_o == (threshold_offset_o != 2'h0); endproperty
    a_on: assert property (p_on) else $error("monitor on wrong");
    property p_lvl; wr_i && addr_i == 4'h8 |=> threshold_offset_o == $past(wdata_i[1:0]); endproperty
    a_lvl: assert property (p_lvl) else $error("threshold not written");
    property p_rdl; rd_i && addr_i == 4'h8 |=> rdata_o == {6'h00, $past(threshold_offset_o)}; endproperty
    a_rdl: assert property (p_rdl) else $error("level readback wrong");
    property p_halt; debug_halt_i [*4] |-> !irq_o; endproperty
    a_halt: assert property (p_halt) else $error("irq during halt");
    // a write may change enable or flag, so hold is only required across quiet cycles
    property p_hold; (!debug_halt_i && !wr_i) [*3] ##0 irq_o |=> irq_o; endproperty
    a_hold: assert property (p_hold) else $error("irq dropped");
    property p_det; (!detector_en_i && !debug_halt_i && !wr_i) [*6] |-> !$rose(irq_o); endproperty
    a_det: assert property (p_det) else $error("flag moved while detector off");
    property p_clr; $stable(below_i) [*6] ##0 (wr_i && addr_i == 4'ha && wdata_i[0]) |=> ##1 !irq_o; endproperty
    a_clr: assert property (p_clr) else $error("flag not cleared");
    property p_sts; (detector_en_i && monitor_on_o && $stable(below_i)) [*6] ##0 (rd_i && addr_i == 4'hb)
        |=> rdata_o == {7'h00, $past(below_i)}; endproperty
    a_sts: assert property (p_sts) else $error("status wrong");
    c_irq: cover property ($rose(irq_o));
    c_clr: cover property (wr_i && addr_i == 4'ha && irq_o);
    c_sts: cover property (rd_i && addr_i == 4'hb && below_i);
endmodule
bind slm_top slm_props u_slm_props (.clk_i, .arst_n_i, .addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o, .below_i,
    .detector_en_i, .debug_halt_i, .threshold_offset_o, .monitor_on_o, .irq_o);

/* sim/slm_supply_model.sv */
/* behavioural supply comparator and brown-out detector facing slm_top, levels in mV.
   assumes the bench sets the supply and the detector command. */
`timescale 1ns/10ps
module slm_supply_model #(
    parameter int BROWNOUT_MV = 2000,
    parameter int RESP_NS     = 20
) (
    input  wire logic [15:0] supply_mv_i,
    input  wire logic [1:0]  offset_i,
    input  wire logic        det_on_i,
    output logic             below_o,
    output logic             detector_en_o
);
    int trip_mv;
    assign trip_mv = BROWNOUT_MV * (95 + 10 * offset_i) / 100;
    // comparator keeps reporting while the detector is off, so re-enabling finds the current level
    assign #(RESP_NS) below_o = (offset_i != 2'h0) && (int'(supply_mv_i) < trip_mv);
    assign #(RESP_NS) detector_en_o = det_on_i;
endmodule

/* sim/tb.sv */
/* self-checking bench for slm_top with the supply model on its analogue side.
   assumes nothing outside; checker arrives by bind. */
`timescale 1ns/10ps
module tb;
    logic        clk_i, arst_n_i, wr_i, rd_i, debug_halt_i, det_cmd;
    logic        below_i, detector_en_i, monitor_on_o, irq_o;
    logic [3:0]  addr_i;
    logic [7:0]  wdata_i, rdata_o;
    logic [1:0]  threshold_offset_o;
    logic [15:0] supply_mv;
    int          n_fail, n_tests;
    slm_top u_slm_top (.clk_i, .arst_n_i, .addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o, .below_i,
        .detector_en_i, .debug_halt_i, .threshold_offset_o, .monitor_on_o, .irq_o);
    slm_supply_model u_slm_supply_model (.supply_mv_i(supply_mv), .offset_i(threshold_offset_o),
        .det_on_i(det_cmd), .below_o(below_i), .detector_en_o(detector_en_i));
    initial begin
        clk_i = 1'b0;
        forever #50 clk_i = ~clk_i;
    end
    task automatic cyc(int n);
        repeat (n) @(posedge clk_i);
        #1;
    endtask
    task automatic chk(logic [7:0] got, logic [7:0] exp);
        n_tests++;
        if (got !== exp) begin
            n_fail++;
            $display("ERROR %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wr(logic [3:0] a, logic [7:0] d);
        addr_i <= a;
        wdata_i <= d;
        wr_i <= 1'b1;
        @(posedge clk_i);
        wr_i <= 1'b0;
        #1;
    endtask
    task automatic rd(logic [3:0] a, logic [7:0] exp);
        addr_i <= a;
        rd_i <= 1'b1;
        @(posedge clk_i);
        rd_i <= 1'b0;
        #1 chk(rdata_o, exp);
    endtask
    // the flag follows a crossing within three edges and irq_o one edge later, so eight is a safe settle
    task automatic supply(int mv);
        supply_mv <= 16'(mv);
        cyc(8);
    endtask
    task automatic t_regs;
        for (int a = 8; a < 13; a++) rd(4'(a), 8'h00);
        for (int c = 0; c < 4; c++) begin
            wr(4'h8, 8'hfc | 8'(c));
            rd(4'h8, 8'(c));
            chk({5'h00, monitor_on_o, threshold_offset_o}, {5'h00, c != 0, 2'(c)});
        end
        wr(4'hb, 8'hff);
        rd(4'hb, 8'h00);
        $display("regs done");
    endtask
    task automatic t_trig;
        for (int c = 0; c < 4; c++) begin
            wr(4'h9, 8'(c * 2 + 1));
            wr(4'ha, 8'h01);
            supply(1000);
            chk({7'h00, irq_o}, 8'(c == 0 || c == 2));
            rd(4'hb, 8'h01);
            wr(4'ha, 8'h01);
            supply(3000);
            chk({7'h00, irq_o}, 8'(c == 1 || c == 2));
            rd(4'ha, 8'(c == 1 || c == 2));
        end
        $display("trigger done");
    endtask
    task automatic t_mask;
        wr(4'h9, 8'h00);
        wr(4'ha, 8'h01);
        supply(1000);
        chk({7'h00, irq_o}, 8'h00);
        rd(4'ha, 8'h01);
        wr(4'h9, 8'h01);
        wr(4'ha, 8'h00);
        chk({7'h00, irq_o}, 8'h01);
        debug_halt_i <= 1'b1;
        cyc(4);
        chk({7'h00, irq_o}, 8'h00);
        debug_halt_i <= 1'b0;
        cyc(4);
        chk({7'h00, irq_o}, 8'h01);
        wr(4'ha, 8'h01);
        cyc(1);
        chk({7'h00, irq_o}, 8'h00);
        supply(3000);
        $display("mask done");
    endtask
    task automatic t_det;
        det_cmd <= 1'b0; // status is left unread while the detector is off
        supply(1000);
        rd(4'ha, 8'h00);
        det_cmd <= 1'b1;
        supply(3000);
        rd(4'ha, 8'h00);
        chk({7'h00, irq_o}, 8'h00);
        $display("detector done");
    endtask
    task automatic finish_test;
        $display("checks %0d failures %0d", n_tests, n_fail);
        if (n_fail == 0 && n_tests > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    initial begin
        repeat (3000) @(posedge clk_i);
        n_fail++;
        finish_test();
    end
    initial begin
        {arst_n_i, wr_i, rd_i, debug_halt_i, addr_i, wdata_i} = '0;
        det_cmd = 1'b1;
        supply_mv = 16'd3000;
        n_fail = 0;
        n_tests = 0;
        cyc(4);
        arst_n_i <= 1'b1;
        cyc(1);
        t_regs();
        t_trig();
        t_mask();
        t_det();
        finish_test();
    end
endmodule
